//--- hw/psc_pkg.sv
// Shared constants and carrier types for the pipelined SRAM cycle control
package psc_pkg;
	// ------------------------------------------------------------------
	// Data organisation
	// ------------------------------------------------------------------
	localparam int LANE_DATA_W = 8;                 // Data bits per byte lane
	localparam int LANE_W      = LANE_DATA_W + 1;   // Data plus parity bit
	localparam int MAX_LANES   = 4;                 // Lanes a..d
	localparam int BUS_W       = MAX_LANES * LANE_W;
	localparam int ADDR_W      = 18;                // Word address width
	localparam int BURST_W     = 2;                 // Burst counter width
	localparam int FIFO_DEPTH  = 8;                 // Write buffer depth
	localparam int SYNC_STAGES = 2;                 // Pin synchroniser depth

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [BURST_W-1:0] BURST_STEP_RST = 2'h0;
	localparam logic [BUS_W-1:0]   BUS_RST        = 36'h0;

	// Sampled control pins
	typedef struct packed {
		logic                 advance_or_load_n;
		logic                 rw_n;
		logic                 clk_enable_n;
		logic                 chip_sel;
		logic                 burst_order_select;
		logic [MAX_LANES-1:0] lane_we_n;
		logic [ADDR_W-1:0]    addr;
	} psc_pin_t;

	// Access travelling down the pipeline
	typedef struct packed {
		logic                 valid;
		logic                 write;
		logic [ADDR_W-1:0]    addr;
		logic [MAX_LANES-1:0] lane_we;
	} psc_cmd_t;

	// Write waiting in the buffer
	typedef struct packed {
		logic [ADDR_W-1:0]    addr;
		logic [BUS_W-1:0]     data;
		logic [MAX_LANES-1:0] lane_we;
	} psc_wr_t;
endpackage

//--- hw/psc_sram_ctrl.sv
// Pipelined SRAM cycle control: write buffer and device-side port logic
//
// Notes on behaviour
// - Read or write is decided only by rw_n sampled at an address load.
// - Cycle type is held across burst advances; only a new load changes it.
// - Write with rw_n low updates only lanes whose write enable is low.
// - All lane enables low writes the whole bus width at once.
// - Burst order select low is linear, high or open is interleaved.
// - Bus splits into lanes a,b (18-bit) or a..d (32/36-bit) with enables.
// - Write data is taken from the data lanes on the rising clock edge.
// - Lane parity bit is stored with 36-bit set, unused with 32-bit.
// - Reserved no-function input is ignored whether driven or open.
// - Advance high steps the burst counter ignoring rw_n; low loads address.
// - Lane enables go with their address and apply to the following data.
// - Low two loaded address bits seed the burst counter.
// - Clock enable high freezes the burst and pipeline stages; the write buffer keeps draining.
`timescale 1ns/100ps

module psc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             i_mclk,
	input  wire logic             i_nrst,
	// Fill side
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	// Drain side
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic      [WIDTH-1:0] o_out_data
);
	localparam int PTR_W = $clog2(DEPTH);
	localparam int CNT_W = $clog2(DEPTH + 1);
	localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

	logic [WIDTH-1:0] store [DEPTH];
	logic [PTR_W-1:0] wr_ptr_ff;
	logic [PTR_W-1:0] rd_ptr_ff;
	logic [CNT_W-1:0] cnt_ff;
	logic [PTR_W-1:0] nxt_wr_ptr;
	logic [PTR_W-1:0] nxt_rd_ptr;
	logic [CNT_W-1:0] nxt_cnt;
	logic             push;
	logic             pop;

	// Step a pointer with wrap at the depth
	function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
		ptr_inc = (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	assign o_in_ready  = (cnt_ff != FULL_CNT);
	assign o_out_valid = (cnt_ff != '0);
	assign o_out_data  = store[rd_ptr_ff];
	assign push        = i_in_valid & o_in_ready;
	assign pop         = o_out_valid & i_out_ready;

	// Pointer and occupancy update
	always_comb begin
		nxt_wr_ptr = push ? ptr_inc(wr_ptr_ff) : wr_ptr_ff;
		nxt_rd_ptr = pop ? ptr_inc(rd_ptr_ff) : rd_ptr_ff;
		nxt_cnt    = cnt_ff;
		if (push && !pop) begin
			nxt_cnt = cnt_ff + 1'b1;
		end else if (pop && !push) begin
			nxt_cnt = cnt_ff - 1'b1;
		end
	end

	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			cnt_ff    <= '0;
		end else begin
			wr_ptr_ff <= nxt_wr_ptr;
			rd_ptr_ff <= nxt_rd_ptr;
			cnt_ff    <= nxt_cnt;
		end
	end

	// Storage, no reset needed
	always_ff @(posedge i_mclk) begin
		if (push) begin
			store[wr_ptr_ff] <= i_in_data;
		end
	end
endmodule // psc_fifo

module psc_sram_ctrl #(
	parameter int NUM_LANES  = 4,   // 2 for the 18-bit set, 4 otherwise
	parameter bit HAS_PARITY = 1'b1 // Parity bits stored (18/36-bit sets)
) (
	// Clock and reset
	input  wire logic                            i_mclk,
	input  wire logic                            i_nrst,
	// Control pins
	input  wire logic                            i_advance_or_load_n,
	input  wire logic                            i_rw_n,
	input  wire logic                            i_clk_enable_n,
	input  wire logic                            i_chip_enable_n,
	input  wire logic                            i_chip_enable2_n,
	input  wire logic                            i_chip_enable2,
	input  wire logic                            i_burst_order_select,
	input  wire logic [psc_pkg::MAX_LANES-1:0]   i_lane_write_enable_n,
	input  wire logic [psc_pkg::ADDR_W-1:0]      i_addr,
	input  wire logic                            i_reserved_no_function,
	// Data lanes, lane x occupies bits [9x+8:9x], parity at the top bit
	input  wire logic [psc_pkg::BUS_W-1:0]       i_lane_data,
	output logic      [psc_pkg::BUS_W-1:0]       o_lane_data,
	output logic      [psc_pkg::BUS_W-1:0]       o_lane_data_oe
);
	import psc_pkg::*;

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	psc_pin_t             pin_raw;
	psc_pin_t             pin_meta_ff;
	psc_pin_t             pin_ff;
	logic [BUS_W-1:0]     dat_meta_ff;
	logic [BUS_W-1:0]     dat_ff;
	logic                 unused_nf;

	// The reserved no-function pin feeds nothing
	assign unused_nf = i_reserved_no_function;

	assign pin_raw.advance_or_load_n  = i_advance_or_load_n;
	assign pin_raw.rw_n               = i_rw_n;
	assign pin_raw.clk_enable_n       = i_clk_enable_n;
	assign pin_raw.chip_sel           = ~i_chip_enable_n & ~i_chip_enable2_n & i_chip_enable2;
	assign pin_raw.burst_order_select = i_burst_order_select;
	assign pin_raw.lane_we_n          = i_lane_write_enable_n;
	assign pin_raw.addr               = i_addr;

	// Two flops per pin before any logic looks at it, except the chip-select decode ahead of them
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			pin_meta_ff <= '1;
			pin_ff      <= '1;
			dat_meta_ff <= BUS_RST;
			dat_ff      <= BUS_RST;
		end else begin
			pin_meta_ff <= pin_raw;
			pin_ff      <= pin_meta_ff;
			dat_meta_ff <= i_lane_data;
			dat_ff      <= dat_meta_ff;
		end
	end

	// ------------------------------------------------------------------
	// Burst sequencing and pipeline
	// ------------------------------------------------------------------
	logic [ADDR_W-1:0]    base_ff;
	logic [BURST_W-1:0]   step_ff;
	logic                 write_ff;
	logic                 active_ff;
	psc_cmd_t             c1_ff;
	psc_cmd_t             c2_ff;
	logic [ADDR_W-1:0]    nxt_base;
	logic [BURST_W-1:0]   nxt_step;
	logic                 nxt_write;
	logic                 nxt_active;
	psc_cmd_t             nxt_c1;
	psc_cmd_t             nxt_c2;
	logic [MAX_LANES-1:0] lane_mask;
	logic [BUS_W-1:0]     bit_mask;
	logic                 stall;
	psc_wr_t              wr_in;
	psc_wr_t              wr_out;
	logic                 wr_push;
	logic                 wr_ready;
	logic                 wr_valid;
	logic                 wr_drain;

	// Burst counter: linear adds the step, interleaved xors it
	function automatic logic [BURST_W-1:0] burst_next(input logic [BURST_W-1:0] seed,
		input logic [BURST_W-1:0] step, input logic interleave);
		burst_next = interleave ? (seed ^ step) : (seed + step);
	endfunction

	// Lanes present in this configuration, parity bits only when stored
	always_comb begin
		lane_mask = '0;
		bit_mask  = '0;
		for (int l = 0; l < MAX_LANES; l++) begin
			if (l < NUM_LANES) begin
				lane_mask[l] = 1'b1;
				bit_mask[l*LANE_W +: LANE_DATA_W] = '1;
				bit_mask[l*LANE_W + LANE_DATA_W]  = HAS_PARITY;
			end
		end
	end

	// Frozen by clock enable high, or while the write buffer is full
	assign stall = pin_ff.clk_enable_n | ~wr_ready;

	always_comb begin
		nxt_base   = base_ff;
		nxt_step   = step_ff;
		nxt_write  = write_ff;
		nxt_active = active_ff;
		nxt_c1     = c1_ff;
		nxt_c2     = c2_ff;
		if (!stall) begin
			nxt_c2 = c1_ff;
			if (!pin_ff.advance_or_load_n) begin
				// New address; rw_n and chip selects count only here
				nxt_base   = pin_ff.addr;
				nxt_step   = BURST_STEP_RST;
				nxt_write  = ~pin_ff.rw_n;
				nxt_active = pin_ff.chip_sel;
				nxt_c1.valid = pin_ff.chip_sel;
				nxt_c1.write = ~pin_ff.rw_n;
				nxt_c1.addr  = pin_ff.addr;
			end else begin
				// Advance: type kept, rw_n ignored
				nxt_step     = step_ff + 1'b1;
				nxt_c1.valid = active_ff;
				nxt_c1.write = write_ff;
				nxt_c1.addr  = {base_ff[ADDR_W-1:BURST_W],
					burst_next(base_ff[BURST_W-1:0], nxt_step, pin_ff.burst_order_select)};
			end
			// Lane enables ride with the address cycle
			nxt_c1.lane_we = ~pin_ff.lane_we_n & lane_mask;
		end
	end

	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			base_ff   <= '0;
			step_ff   <= BURST_STEP_RST;
			write_ff  <= 1'b0;
			active_ff <= 1'b0;
			c1_ff     <= '0;
			c2_ff     <= '0;
		end else begin
			base_ff   <= nxt_base;
			step_ff   <= nxt_step;
			write_ff  <= nxt_write;
			active_ff <= nxt_active;
			c1_ff     <= nxt_c1;
			c2_ff     <= nxt_c2;
		end
	end

	// ------------------------------------------------------------------
	// Write buffer: data follows its address by two cycles
	// ------------------------------------------------------------------
	assign wr_in.addr    = c2_ff.addr;
	assign wr_in.data    = dat_ff & bit_mask;
	assign wr_in.lane_we = c2_ff.lane_we;
	assign wr_push       = c2_ff.valid & c2_ff.write & ~pin_ff.clk_enable_n;
	// Array port is shared: a read in flight holds off the drain
	assign wr_drain      = ~(c1_ff.valid & ~c1_ff.write & ~stall);

	psc_fifo #(
		.WIDTH ($bits(psc_wr_t)),
		.DEPTH (FIFO_DEPTH)
	) u_wr_fifo (
		.i_mclk      (i_mclk),
		.i_nrst      (i_nrst),
		.i_in_valid  (wr_push),
		.o_in_ready  (wr_ready),
		.i_in_data   (wr_in),
		.o_out_valid (wr_valid),
		.i_out_ready (wr_drain),
		.o_out_data  (wr_out)
	);

	// ------------------------------------------------------------------
	// Array and read return
	// ------------------------------------------------------------------
	logic [BUS_W-1:0] mem [2**ADDR_W];
	logic [BUS_W-1:0] rd_data_ff;
	logic [BUS_W-1:0] oe_ff;
	logic [BUS_W-1:0] nxt_rd_data;
	logic [BUS_W-1:0] nxt_oe;

	// Byte-lane write; all enables low covers the full width
	always_ff @(posedge i_mclk) begin
		if (wr_valid && wr_drain) begin
			for (int l = 0; l < MAX_LANES; l++) begin
				if (wr_out.lane_we[l]) begin
					mem[wr_out.addr][l*LANE_W +: LANE_W] <= wr_out.data[l*LANE_W +: LANE_W];
				end
			end
		end
	end

	// Read word appears with the cycle its data belongs to
	always_comb begin
		nxt_rd_data = rd_data_ff;
		nxt_oe      = oe_ff;
		if (!stall) begin
			nxt_oe = (c1_ff.valid && !c1_ff.write) ? bit_mask : '0;
			if (c1_ff.valid && !c1_ff.write) begin
				nxt_rd_data = mem[c1_ff.addr] & bit_mask;
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			rd_data_ff <= BUS_RST;
			oe_ff      <= BUS_RST;
		end else begin
			rd_data_ff <= nxt_rd_data;
			oe_ff      <= nxt_oe;
		end
	end

	assign o_lane_data    = rd_data_ff;
	assign o_lane_data_oe = oe_ff;
endmodule // psc_sram_ctrl

//--- dv/psc_sram_ctrl_props.sv
// Assertion checker for the SRAM port outputs
`timescale 1ns/100ps
module psc_sram_ctrl_props (
	// Clock and reset
	input wire logic                      i_mclk,
	input wire logic                      i_nrst,
	// Control pins
	input wire logic                      i_advance_or_load_n,
	input wire logic                      i_rw_n,
	input wire logic                      i_clk_enable_n,
	input wire logic                      i_chip_enable_n,
	input wire logic                      i_chip_enable2_n,
	input wire logic                      i_chip_enable2,
	// Data outputs
	input wire logic [psc_pkg::BUS_W-1:0] o_lane_data,
	input wire logic [psc_pkg::BUS_W-1:0] o_lane_data_oe
);
	import psc_pkg::*;
	logic sel;
	logic ld;
	logic full;
	logic none;
	// Load decode and drive-enable shapes
	assign sel  = !i_chip_enable_n && !i_chip_enable2_n && i_chip_enable2;
	assign ld   = !i_advance_or_load_n;
	assign full = o_lane_data_oe == '1;
	assign none = o_lane_data_oe == '0;
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_nrst);
	// Five unfrozen edges: a pin cycle and its answer four edges on
	sequence s_run; (!i_clk_enable_n)[*5]; endsequence
	// Loads decide the beat by rw_n and chip selects only
	property p_rd; s_run ##0 $past(ld && i_rw_n && sel, 4) |-> full; endproperty
	a_rd: assert property (p_rd) else $error("read load not answered");
	property p_wr; s_run ##0 $past(ld && !i_rw_n, 4) |-> none; endproperty
	a_wr: assert property (p_wr) else $error("write load drove bus");
	property p_ds; s_run ##0 $past(ld && !sel, 4) |-> none; endproperty
	a_ds: assert property (p_ds) else $error("deselected load drove bus");
	// Advances keep the type of the beat before
	property p_ar; s_run ##0 $past(!ld, 4) && $past(full) |-> full; endproperty
	a_ar: assert property (p_ar) else $error("read burst broke on advance");
	property p_aq; s_run ##0 $past(!ld, 4) && $past(none) |-> none; endproperty
	a_aq: assert property (p_aq) else $error("advance turned into read");
	// Frozen pin cycle stalls the output stage two edges later
	property p_frz; i_clk_enable_n |-> ##3 $stable(o_lane_data_oe) && $stable(o_lane_data); endproperty
	a_frz: assert property (p_frz) else $error("outputs moved while frozen");
	// Lanes are driven all together and data moves only with a beat
	property p_shape; full || none; endproperty
	a_shape: assert property (p_shape) else $error("partial lane drive");
	property p_hold; none |-> $stable(o_lane_data); endproperty
	a_hold: assert property (p_hold) else $error("data moved without beat");
endmodule // psc_sram_ctrl_props

bind psc_sram_ctrl psc_sram_ctrl_props props_u (
	.i_mclk(i_mclk),
	.i_nrst(i_nrst),
	.i_advance_or_load_n(i_advance_or_load_n),
	.i_rw_n(i_rw_n),
	.i_clk_enable_n(i_clk_enable_n),
	.i_chip_enable_n(i_chip_enable_n),
	.i_chip_enable2_n(i_chip_enable2_n),
	.i_chip_enable2(i_chip_enable2),
	.o_lane_data(o_lane_data),
	.o_lane_data_oe(o_lane_data_oe)
);

//--- dv/psc_ctrl_model.sv
// Controller-side model driving the SRAM port pins
`timescale 1ns/100ps
module psc_ctrl_model (
	// Clock
	input  wire logic                      i_mclk,
	// Device data side
	input  wire logic [psc_pkg::BUS_W-1:0] i_rdata,
	input  wire logic [psc_pkg::BUS_W-1:0] i_oe,
	// Port pins
	output psc_pkg::psc_pin_t              o_pins,
	output logic      [psc_pkg::BUS_W-1:0] o_bus
);
	import psc_pkg::*;
	logic [2:0][BUS_W-1:0] dq  = '0;
	logic [2:0]            de  = 3'h0;
	logic                  tog = 1'b0;
	// Idle pins: deselected load, clock enabled, linear order
	initial o_pins = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 4'hf, 18'h0};
	// Released lanes toggle so stale data never looks valid
	always @(posedge i_mclk) tog <= !tog;
	// Wire level from both parties' enables
	assign o_bus = (i_oe & i_rdata) | (~i_oe & (de[2] ? dq[2] : {BUS_W{tog}}));
	// One pin cycle; its data goes on the lanes two cycles later
	task automatic beat(input logic ld, input logic rd, input logic sel,
		input logic [ADDR_W-1:0] a, input logic [3:0] wen, input logic [BUS_W-1:0] d,
		input logic den);
		@(posedge i_mclk);
		#1;
		o_pins.advance_or_load_n = !ld;
		o_pins.rw_n = rd;
		o_pins.chip_sel = sel;
		o_pins.lane_we_n = wen;
		o_pins.addr = a;
		o_pins.clk_enable_n = 1'b0;
		dq = {dq[1:0], d};
		de = {de[1:0], den};
	endtask
	// Frozen edges; pins and waiting data stay put
	task automatic hold(input int n);
		repeat (n) begin
			@(posedge i_mclk);
			#1;
			o_pins.clk_enable_n = 1'b1;
		end
	endtask
	// Burst order is changed only while the device is in reset
	task automatic order(input logic lin);
		o_pins.burst_order_select = !lin;
	endtask
endmodule // psc_ctrl_model

//--- dv/psc_sram_ctrl_tb_top.sv
// Testbench for the pipelined SRAM cycle control
`timescale 1ns/100ps
module psc_sram_ctrl_tb_top;
	import psc_pkg::*;
	localparam logic [ADDR_W-1:0] BASE = 18'h2a5c0;
	logic             mclk    = 1'b0;
	logic             nrst    = 1'b0;
	logic             rsv     = 1'b0;
	logic             lin     = 1'b1;
	logic [2:0]       ce_hist = 3'h0;
	psc_pin_t         pins;
	logic [BUS_W-1:0] bus;
	logic [BUS_W-1:0] rdat;
	logic [BUS_W-1:0] oe;
	logic [BUS_W-1:0] mem [4];
	logic [BUS_W-1:0] rq [$];
	int               failures = 0;
	int               n_checks = 0;
	// Clock, and a reserved pin that never rests
	always #5 mclk = !mclk;
	always @(posedge mclk) rsv <= #1 !rsv;
	// Collect read beats mid-cycle, where outputs are settled
	// A beat held by a frozen pin cycle two edges back counts once
	always @(negedge mclk) begin
		if (oe === '1 && !ce_hist[2])
			rq.push_back(rdat);
		ce_hist <= {ce_hist[1:0], pins.clk_enable_n};
	end
	psc_sram_ctrl dut_u (
		.i_mclk(mclk),
		.i_nrst(nrst),
		.i_advance_or_load_n(pins.advance_or_load_n),
		.i_rw_n(pins.rw_n),
		.i_clk_enable_n(pins.clk_enable_n),
		.i_chip_enable_n(!pins.chip_sel),
		.i_chip_enable2_n(!pins.chip_sel),
		.i_chip_enable2(pins.chip_sel),
		.i_burst_order_select(pins.burst_order_select),
		.i_lane_write_enable_n(pins.lane_we_n),
		.i_addr(pins.addr),
		.i_reserved_no_function(rsv),
		.i_lane_data(bus),
		.o_lane_data(rdat),
		.o_lane_data_oe(oe)
	);
	psc_ctrl_model mdl_u (.i_mclk(mclk), .i_rdata(rdat), .i_oe(oe), .o_pins(pins), .o_bus(bus));
	// Compare one bus word
	task automatic chk(input string what, input logic [BUS_W-1:0] exp, input logic [BUS_W-1:0] got);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic stop_test();
		if (failures == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Distinct word per index, parity bits included
	function automatic logic [BUS_W-1:0] pat(input int i);
		return 36'h9_5a3c_e1b7 ^ (36'h1_0842_1085 * 36'(i));
	endfunction
	// Expected array update, lane by lane
	task automatic put(input int a, input logic [3:0] wen, input logic [BUS_W-1:0] d);
		for (int l = 0; l < MAX_LANES; l++)
			if (!wen[l])
				mem[a][l*LANE_W +: LANE_W] = d[l*LANE_W +: LANE_W];
	endtask
	task automatic idle(input int n);
		repeat (n) mdl_u.beat(1'b1, 1'b1, 1'b0, BASE, 4'hf, '0, 1'b0);
	endtask
	// Four-beat read from seed s, optionally frozen after the load
	task automatic rd_burst(input logic [1:0] s, input int gap);
		logic [1:0] a;
		rq.delete();
		mdl_u.beat(1'b1, 1'b1, 1'b1, BASE | 18'(s), 4'hf, '0, 1'b0);
		mdl_u.hold(gap);
		repeat (3) mdl_u.beat(1'b0, 1'b0, 1'b1, BASE, 4'h0, '0, 1'b0);
		idle(8);
		chk("beat count", 36'(4), 36'(rq.size()));
		for (int k = 0; k < 4; k++) begin
			a = lin ? s + 2'(k) : s ^ 2'(k);
			chk("read word", mem[a], rq[k]);
		end
	endtask
	// Back-to-back single writes, every lane enabled
	task automatic t_full_writes();
		for (int i = 0; i < 4; i++) begin
			mdl_u.beat(1'b1, 1'b0, 1'b1, BASE | 18'(i), 4'h0, pat(i), 1'b1);
			put(i, 4'h0, pat(i));
		end
		idle(12);
	endtask
	// Lane write, then an advance with rw_n high that must stay a write
	task automatic t_lane_burst();
		mdl_u.beat(1'b1, 1'b0, 1'b1, BASE | 18'h2, 4'h5, pat(7), 1'b1);
		put(2, 4'h5, pat(7));
		mdl_u.beat(1'b0, 1'b1, 1'b1, BASE, 4'h0, pat(8), 1'b1);
		put(3, 4'h0, pat(8));
		idle(12);
	endtask
	// Watchdog at 500 cycles, far beyond the roughly 105 cycles the run needs
	initial begin
		#5000;
		failures++;
		stop_test();
	end
	initial begin
		repeat (12) @(posedge mclk);
		#1 nrst = 1'b1;
		t_full_writes();
		rd_burst(2'h1, 0);
		t_lane_burst();
		rd_burst(2'h2, 0);
		rq.delete();
		idle(10);
		chk("deselected beats", 36'(0), 36'(rq.size()));
		nrst = 1'b0;
		lin = 1'b0;
		mdl_u.order(1'b0);
		repeat (3) @(posedge mclk);
		#1 nrst = 1'b1;
		rd_burst(2'h1, 2);
		rd_burst(2'h3, 0);
		stop_test();
	end
endmodule // psc_sram_ctrl_tb_top
